// ---- core/flow_pkg.sv ----
/*
 * constants shared by the program-flow and configuration block.
 * assumes a single instruction-cycle clock drives all users.
 */
`default_nettype none
package flow_pkg;
    localparam int          PC_W_MAX       = 11;
    localparam int          CFG_W          = 6;
    localparam logic [5:0]  CFG_RESET      = 6'h3f;
    localparam int          CFG_CLK_SRC    = 5;
    localparam int          CFG_EDGE       = 4;
    localparam int          CFG_PSA        = 3;
    localparam int          CFG_RATE_LO    = 0;
    localparam int          CFG_RATE_W     = 3;
    localparam int          PAGE_LO        = 9;
    localparam int          STATUS_PAGE_LO = 5;
    localparam int          PTR_ADDR_W     = 5;
    localparam logic [6:0]  INDIRECT_ADDR  = 7'h00;
    localparam logic [7:0]  INDIRECT_ZERO  = 8'h00;
    typedef enum logic [2:0] {
        OP_SEQ    = 3'b000,
        OP_JUMP   = 3'b001,
        OP_CALL   = 3'b010,
        OP_RETURN = 3'b011,
        OP_PCL_WR = 3'b100,
        OP_OPTION = 3'b101
    } flow_op_e;
endpackage
`default_nettype wire

// ---- core/return_stack.sv ----
/*
 * two-level return stack.
 * assumes push and pop are never asserted together.
 */
`default_nettype none
module return_stack #(
    parameter int W = 11
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_push,
    input  wire logic         i_pop,
    input  wire logic [W-1:0] i_push_val,
    output logic      [W-1:0] o_top
);
    logic [W-1:0] lvl_q [2];

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lvl_q[0] <= '0;
            lvl_q[1] <= '0;
        end else if (i_push) begin
            lvl_q[1] <= lvl_q[0];
            lvl_q[0] <= i_push_val;
        end else if (i_pop) begin
            lvl_q[0] <= lvl_q[1];
        end
    end

    assign o_top = lvl_q[0];
endmodule // return_stack
`default_nettype wire

// ---- core/pc_stack_option_indirect.sv ----
/*
 * program counter, return stack, option register and indirect addressing
 * of a small 8-bit core. assumes the execution logic presents one
 * operation per instruction cycle, on the same clock.
 */
`default_nettype none
module pc_stack_option_indirect
    import flow_pkg::*;
#(
    parameter int PC_W = flow_pkg::PC_W_MAX
) (
    input  wire logic                      i_ref_clk,
    input  wire logic                      i_arst_n,
    input  wire flow_pkg::flow_op_e        i_op,
    input  wire logic [8:0]                i_insn_addr,
    input  wire logic [7:0]                i_pcl_value,
    input  wire logic [7:0]                i_w_value,
    input  wire logic [7:0]                i_literal,
    input  wire logic [7:0]                i_status,
    input  wire logic [6:0]                i_file_addr,
    input  wire logic                      i_file_wr,
    input  wire logic [6:0]                i_pointer,
    input  wire logic [7:0]                i_file_rdata,
    output logic      [PC_W-1:0]           o_pc,
    output logic      [7:0]                o_pc_low_latch,
    output logic                           o_timer_clock_source_sel,
    output logic                           o_timer_edge_sel,
    output logic                           o_prescaler_assign,
    output logic      [2:0]                o_prescaler_rate,
    output logic      [8:0]                o_timer_div,
    output logic      [7:0]                o_watchdog_div,
    output logic                           o_w_load,
    output logic      [7:0]                o_w_value,
    output logic      [6:0]                o_eff_addr,
    output logic                           o_eff_wr,
    output logic      [7:0]                o_ind_rdata
);
    import flow_pkg::*;

    logic            rst_s1_q;
    logic            rst_n_q;
    logic [PC_W-1:0] pc_q;
    logic [PC_W-1:0] pc_d;
    logic [CFG_W-1:0] cfg_q;
    logic [8:0]      timer_div_q;
    logic [7:0]      wdog_div_q;
    logic            w_load_q;
    logic [7:0]      w_val_q;
    logic [6:0]      eff_addr_q;
    logic            eff_wr_q;
    logic [7:0]      ind_rdata_q;
    logic [PC_W-1:0] stack_top;
    logic [PC_W-1:0] pc_inc;
    logic [PC_W-1:0] page_bits;
    logic            is_ind;
    logic            ptr_zero;
    logic            self_write;
    logic [6:0]      eff_addr_d;

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    return_stack #(
        .W (PC_W)
    ) u_stack (
        .i_clk      (i_ref_clk),
        .i_rst_n    (rst_n_q),
        .i_push     (i_op == OP_CALL),
        .i_pop      (i_op == OP_RETURN),
        .i_push_val (pc_inc),
        .o_top      (stack_top)
    );

    // natural wrap carries into the page bits
    assign pc_inc = pc_q + PC_W'(1);

    // page bits 9 and up from status; parts with a 9-bit pc ignore them
    // the status owner clears them on reset, so page 0 is preselected
    generate
        if (PC_W > PAGE_LO) begin : g_paged
            assign page_bits = PC_W'({i_status[STATUS_PAGE_LO +: PC_W-PAGE_LO],
                                      9'h000});
        end else begin : g_flat
            assign page_bits = '0;
        end
    endgenerate

    always_comb begin
        pc_d = pc_inc;
        case (i_op)
            OP_JUMP:   pc_d = page_bits | PC_W'(i_insn_addr);
            OP_CALL:   pc_d = page_bits | PC_W'({1'b0, i_insn_addr[7:0]});
            OP_PCL_WR: pc_d = page_bits | PC_W'({1'b0, i_pcl_value});
            OP_RETURN: pc_d = stack_top;
            default:   pc_d = pc_inc;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pc_q <= '1;
        end else begin
            pc_q <= pc_d;
        end
    end

    always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cfg_q       <= CFG_RESET;
            timer_div_q <= 9'(9'h002 << CFG_RESET[CFG_RATE_LO +: CFG_RATE_W]);
            wdog_div_q  <= 8'(8'h01 << CFG_RESET[CFG_RATE_LO +: CFG_RATE_W]);
        end else if (i_op == OP_OPTION) begin
            cfg_q       <= i_w_value[CFG_W-1:0];
            timer_div_q <= 9'(9'h002 << i_w_value[CFG_RATE_LO +: CFG_RATE_W]);
            wdog_div_q  <= 8'(8'h01 << i_w_value[CFG_RATE_LO +: CFG_RATE_W]);
        end
    end

    always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            w_load_q <= 1'b0;
            w_val_q  <= 8'h00;
        end else begin
            w_load_q <= (i_op == OP_RETURN);
            w_val_q  <= i_literal;
        end
    end

    // indirect port resolution
    assign is_ind     = (i_file_addr == INDIRECT_ADDR);
    assign ptr_zero   = (i_pointer == INDIRECT_ADDR);
    assign self_write = is_ind && ptr_zero;
    assign eff_addr_d = is_ind ? {i_pointer[6:PTR_ADDR_W],
                                  i_pointer[PTR_ADDR_W-1:0]} : i_file_addr;

    always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            eff_addr_q  <= 7'h00;
            eff_wr_q    <= 1'b0;
            ind_rdata_q <= 8'h00;
        end else begin
            eff_addr_q  <= eff_addr_d;
            eff_wr_q    <= i_file_wr && !self_write;
            ind_rdata_q <= self_write || (is_ind && ptr_zero) ?
                           INDIRECT_ZERO : i_file_rdata;
        end
    end

    // the pc low latch reads pc bits 7..0 directly
    assign o_pc_low_latch = pc_q[7:0];
    assign o_pc           = pc_q;
    assign o_timer_clock_source_sel = cfg_q[CFG_CLK_SRC];
    assign o_timer_edge_sel         = cfg_q[CFG_EDGE];
    assign o_prescaler_assign       = cfg_q[CFG_PSA];
    assign o_prescaler_rate         = cfg_q[CFG_RATE_LO +: CFG_RATE_W];
    // one-hot divide ratios, registered alongside the rate bits
    assign o_timer_div    = timer_div_q;
    assign o_watchdog_div = wdog_div_q;
    assign o_w_load       = w_load_q;
    assign o_w_value      = w_val_q;
    assign o_eff_addr     = eff_addr_q;
    assign o_eff_wr       = eff_wr_q;
    assign o_ind_rdata    = ind_rdata_q;
    // the option register has no read path; bits 7..6 are absent
endmodule // pc_stack_option_indirect
`default_nettype wire

// ---- verif/exec_model.sv ----
/* partner model: execution side of the core, holding file contents and w.
   assumes one instruction-cycle clock shared with the block. */
`default_nettype none
module exec_model (
    input  wire logic       i_clk,
    input  wire logic [6:0] i_ptr,
    input  wire logic       i_w_load,
    input  wire logic [7:0] i_w_value,
    output logic      [7:0] o_rdata,
    output logic      [7:0] o_w_q
);
    // each file location holds a pattern derived from its address
    assign o_rdata = 8'h10 ^ {1'b0, i_ptr};
    always_ff @(posedge i_clk) if (i_w_load) o_w_q <= i_w_value;
endmodule // exec_model
`default_nettype wire

// ---- verif/pc_flow_assertions.sv ----
/* concurrent checks on the top ports of pc_stack_option_indirect.
   assumes bind from the bench and one clock domain. */
`default_nettype none
module pc_flow_assertions
    import flow_pkg::*;
#(parameter int PC_W = 11) (
    input wire logic            i_ref_clk,
    input wire logic            i_arst_n,
    input wire flow_op_e        i_op,
    input wire logic [8:0]      i_insn_addr,
    input wire logic [7:0]      i_pcl_value,
    input wire logic [7:0]      i_w_value,
    input wire logic [7:0]      i_literal,
    input wire logic [7:0]      i_status,
    input wire logic [PC_W-1:0] o_pc,
    input wire logic [2:0]      o_prescaler_rate,
    input wire logic [8:0]      o_timer_div,
    input wire logic [7:0]      o_watchdog_div,
    input wire logic            o_w_load,
    input wire logic [7:0]      o_w_value
);
    logic [1:0] up_q;
    // ops count only once the internal reset copy has released
    always_ff @(posedge i_ref_clk or negedge i_arst_n)
        if (!i_arst_n) up_q <= 2'h0;
        else if (up_q != 2'h3) up_q <= up_q + 2'h1;
    wire live = up_q == 2'h3;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);
    sequence s_call; live && i_op == OP_CALL; endsequence
    sequence s_ret; i_op == OP_RETURN; endsequence
    seq_incr_a: assert property (live && i_op == OP_SEQ |=> o_pc == $past(o_pc) + 1'b1)
        else $error("pc not advanced");
    jump_load_a: assert property (live && i_op == OP_JUMP |=>
        o_pc == PC_W'({$past(i_status[6:5]), $past(i_insn_addr)})) else $error("jump target");
    call_load_a: assert property (s_call |=> o_pc[8:0] == {1'b0, $past(i_insn_addr[7:0])})
        else $error("call target");
    pcl_write_a: assert property (live && i_op == OP_PCL_WR |=>
        o_pc[8:0] == {1'b0, $past(i_pcl_value)}) else $error("low latch write");
    call_return_a: assert property (s_call ##1 s_ret |=> o_pc == $past(o_pc, 2) + 1'b1)
        else $error("return address");
    w_literal_a: assert property (live && i_op == OP_RETURN |=>
        o_w_load && o_w_value == $past(i_literal)) else $error("return literal");
    option_load_a: assert property (live && i_op == OP_OPTION |=>
        o_prescaler_rate == $past(i_w_value[2:0])) else $error("option load");
    div_decode_a: assert property (o_timer_div == 9'h2 << o_prescaler_rate &&
        o_watchdog_div == 8'h1 << o_prescaler_rate) else $error("divider decode");
endmodule // pc_flow_assertions
`default_nettype wire

// ---- verif/pc_stack_option_indirect_bench.sv ----
/* bench: steps ops at the falling edge, checks pc, stack, option, indirect.
   assumes the default 11-bit pc and the exec_model partner. */
`default_nettype none
module pc_stack_option_indirect_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import flow_pkg::*;
    logic        i_ref_clk = 1'b0, i_arst_n = 1'b0, i_file_wr = 1'b0;
    flow_op_e    i_op = OP_SEQ;
    logic [8:0]  i_insn_addr = 9'h000, o_timer_div;
    logic [7:0]  i_pcl_value = 8'h00, i_w_value = 8'h00, i_literal = 8'h00, i_status = 8'h00;
    logic [6:0]  i_file_addr = 7'h00, i_pointer = 7'h00, o_eff_addr;
    logic [7:0]  i_file_rdata, w_q, o_pc_low_latch, o_w_value, o_ind_rdata, o_watchdog_div;
    logic [10:0] o_pc;
    logic [2:0]  o_prescaler_rate;
    logic        o_timer_clock_source_sel, o_timer_edge_sel, o_prescaler_assign, o_w_load, o_eff_wr;
    int          err_total = 0, checks_done = 0;
    wire  [5:0]  opt = {o_timer_clock_source_sel, o_timer_edge_sel, o_prescaler_assign,
                        o_prescaler_rate};
    pc_stack_option_indirect u_dut (.*);
    exec_model u_exec (.i_clk(i_ref_clk), .i_ptr(i_pointer), .i_w_load(o_w_load),
                       .i_w_value(o_w_value), .o_rdata(i_file_rdata), .o_w_q(w_q));
    always #2.5 i_ref_clk = ~i_ref_clk;
    task automatic chk(string n, logic [31:0] e, logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic step(flow_op_e op);
        i_op = op;
        @(negedge i_ref_clk);
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #20us;
        err_total++;
        final_report;
    end
    initial begin
        repeat (16) @(negedge i_ref_clk);
        chk("reset", {11'h7ff, 6'h3f}, {o_pc, opt});
        i_arst_n = 1'b1;
        repeat (3) @(negedge i_ref_clk);
        $display("end reset");
        i_status = 8'h20;
        i_insn_addr = 9'h1ab;
        step(OP_JUMP);
        chk("jump", 11'h3ab, o_pc);
        step(OP_SEQ);
        chk("seq", 11'h3ac, o_pc);
        i_status = 8'h60;
        i_pcl_value = 8'hff;
        step(OP_PCL_WR);
        chk("pcl", {11'h6ff, 8'hff}, {o_pc, o_pc_low_latch});
        i_status = 8'h00;
        i_insn_addr = 9'h1ff;
        step(OP_JUMP);
        chk("jump0", 11'h1ff, o_pc);
        step(OP_SEQ);
        chk("cross", 11'h200, o_pc);
        $display("end branch");
        i_status = 8'h40;
        i_insn_addr = 9'h1cd;
        step(OP_CALL);
        chk("call1", 11'h4cd, o_pc);
        i_status = 8'h00;
        i_insn_addr = 9'h012;
        step(OP_CALL);
        chk("call2", 11'h012, o_pc);
        i_literal = 8'h5a;
        step(OP_RETURN);
        chk("ret1", {11'h4ce, 1'b1, 8'h5a}, {o_pc, o_w_load, o_w_value});
        step(OP_RETURN);
        chk("ret2", 11'h201, o_pc);
        step(OP_RETURN);
        chk("ret3", 11'h201, o_pc);
        step(OP_SEQ);
        chk("w", 8'h5a, w_q);
        $display("end stack");
        for (int n = 0; n < 8; n++) begin
            i_w_value = {2'b11, 3'(n), 3'(n)};
            step(OP_OPTION);
            chk("opt", {3'(n), 3'(n)}, opt);
            chk("div", {9'h2 << n, 8'h1 << n}, {o_timer_div, o_watchdog_div});
        end
        $display("end option");
        i_pointer = 7'h08;
        i_file_wr = 1'b1;
        step(OP_SEQ);
        chk("ind", {1'b1, 7'h08, 8'h18}, {o_eff_wr, o_eff_addr, o_ind_rdata});
        i_pointer = 7'h00;
        step(OP_SEQ);
        chk("ind0", 9'h000, {o_eff_wr, o_ind_rdata});
        $display("end indirect");
        final_report;
    end
endmodule // pc_stack_option_indirect_bench
bind pc_stack_option_indirect pc_flow_assertions #(.PC_W(PC_W)) u_chk (.*);
`default_nettype wire
